// file: event_status_and_fifo_trigger.sv
// Event status registers, gate error timer and FIFO trigger freeze
//
// Operation
// - In trigger mode an enabled event flag freezes the FIFO, keeping 32 samples.
// - Five trigger enables select freezing events; all reset to zero.
// - Gate error flag resets 0, sets on error, clears when FIFO empties.
// - Five-bit timer counts rate ticks since gate error; cleared with flag.
// - Two-bit mode field: 00 standby, 01 wake, 10 sleep; resets standby.
// - Each flag reads 1 while its function has an interrupt asserted.
// - Reading the flag register clears only the vector-magnitude bit.
// - Auto-sleep bit sets on any wake/sleep transition event.
// - Wake goes to sleep, low rate, when inactivity exceeds the limit.
// - Sleep goes to wake, higher rate, on a chosen wake event.
// - Reading the mode register clears the auto-sleep bit.
// - FIFO bit sets on overflow or watermark; clears on FIFO status read.
// - Transient bit sets on active transient with enable; clears on its read.
// - Orientation bit sets on changed orientation with enable; clears on its read.
// - Vector-magnitude bit clears on reading the flag register.
// - Pulse bit sets on active pulse with enable; clears on pulse source read.
// - FIFO trigger mode is setting 2'b11; watermark then means trigger seen.
`timescale 1ns/10ps
module event_status_and_fifo_trigger
  import evt_status_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic odr_tick,
  input wire logic active,
  input wire logic slpe,
  input wire logic inact_expired,
  input wire logic wake_evt,
  input wire logic [1:0] fifo_mode,
  input wire logic fifo_push,
  input wire logic fifo_ovf,
  input wire logic fifo_wmrk,
  input wire logic fifo_empty,
  input wire logic gate_error_evt,
  input wire logic fifo_status_rd,
  input wire logic trans_event_active_flag,
  input wire logic trans_int_en,
  input wire logic trans_src_rd,
  input wire logic orient_changed,
  input wire logic orient_int_en,
  input wire logic orientation_state_register_rd,
  input wire logic pulse_event_active_flag,
  input wire logic pulse_int_en,
  input wire logic pulse_src_rd,
  input wire logic ffmt_event_active_flag,
  input wire logic ffmt_int_en,
  input wire logic ffmt_src_rd,
  input wire logic vecm_evt,
  input wire logic vecm_int_en,
  input wire logic drdy_evt,
  input wire logic drdy_clr,
  output logic fifo_freeze,
  output logic sleep_rate,
  output logic [1:0] sys_mode,
  output logic [7:0] int_flags
);
  import evt_status_pkg::*;

  // ==========================================================
  // Mode sequencer
  mode_link_if link ();

  assign link.active = active;
  assign link.slpe = slpe;
  assign link.inact_expired = inact_expired;
  assign link.wake_evt = wake_evt;

  mode_sequencer u_seq (
    .clock(clock),
    .sys_rst(sys_rst),
    .link(link.seq)
  );

  // ==========================================================
  // Register state
  logic [7:0] trig_q;
  logic [7:0] trig_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic gerr_q;
  logic gerr_d;
  logic [GT_W-1:0] gt_q;
  logic [GT_W-1:0] gt_d;
  logic freeze_q;
  logic freeze_d;
  logic fifo_lvl_q;
  logic fifo_lvl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [7:0] sys_word;
  logic rd_sys;
  logic rd_flags;

  // Register read decode
  assign rd_sys = reg_rd && (reg_addr == ADDR_SYS_MODE);
  assign rd_flags = reg_rd && (reg_addr == ADDR_INT_FLAGS);
  assign sys_word = {gerr_q, gt_q, link.mode};

  // Flag set and clear terms
  always_comb
  begin
    set_v = FLAGS_RESET;
    clr_v = FLAGS_RESET;
    set_v[BIT_ASLP] = link.aslp_evt;
    set_v[BIT_FIFO] = (fifo_ovf || fifo_wmrk) && (fifo_push || !fifo_lvl_q);
    set_v[BIT_TRANS] = trans_event_active_flag && trans_int_en;
    set_v[BIT_ORIENT] = orient_changed && orient_int_en;
    set_v[BIT_PULSE] = pulse_event_active_flag && pulse_int_en;
    set_v[BIT_FFMT] = ffmt_event_active_flag && ffmt_int_en;
    set_v[BIT_VECM] = vecm_evt && vecm_int_en;
    set_v[BIT_DRDY] = drdy_evt;
    clr_v[BIT_ASLP] = rd_sys;
    clr_v[BIT_FIFO] = fifo_status_rd;
    clr_v[BIT_TRANS] = trans_src_rd;
    clr_v[BIT_ORIENT] = orientation_state_register_rd;
    clr_v[BIT_PULSE] = pulse_src_rd;
    clr_v[BIT_FFMT] = ffmt_src_rd;
    clr_v[BIT_VECM] = rd_flags;
    clr_v[BIT_DRDY] = drdy_clr;
  end

  // Next register values; a set beats a clear for the flags and gate error, while leaving trigger mode beats a freeze
  always_comb
  begin
    trig_d = trig_q;
    if (reg_wr && reg_addr == ADDR_TRIG_SEL)
      trig_d = reg_wdata & TRIG_MASK;
    flags_d = (flags_q & ~clr_v) | set_v;
    fifo_lvl_d = fifo_ovf || fifo_wmrk;
    gerr_d = gate_error_evt || (gerr_q && !fifo_empty);
    gt_d = gt_q;
    if (!gerr_q || !gerr_d)
      gt_d = GT_RESET;
    else if (odr_tick && gt_q != GT_MAX)
      gt_d = gt_q + 5'h01;
    freeze_d = freeze_q;
    if (fifo_mode != FIFO_MODE_TRIGGER)
      freeze_d = 1'b0;
    else if (|(flags_q & trig_q))
      freeze_d = 1'b1;
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_TRIG_SEL: rdata_d = trig_q;
        ADDR_SYS_MODE: rdata_d = sys_word;
        ADDR_INT_FLAGS: rdata_d = flags_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trig_q <= TRIG_RESET;
      flags_q <= FLAGS_RESET;
      fifo_lvl_q <= 1'b0;
      gerr_q <= 1'b0;
      gt_q <= GT_RESET;
      freeze_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      trig_q <= trig_d;
      flags_q <= flags_d;
      fifo_lvl_q <= fifo_lvl_d;
      gerr_q <= gerr_d;
      gt_q <= gt_d;
      freeze_q <= freeze_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign fifo_freeze = freeze_q;
  assign int_flags = flags_q;
  assign sys_mode = link.mode;
  assign sleep_rate = link.sleep_rate;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_freeze;
    fifo_mode == FIFO_MODE_TRIGGER && |(flags_q & trig_q) |=> fifo_freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("FIFO not frozen");

  property p_trig_write;
    reg_wr && reg_addr == ADDR_TRIG_SEL |=> trig_q == ($past(reg_wdata) & TRIG_MASK);
  endproperty
  a_trig_write: assert property (p_trig_write) else $error("Bad trigger select");

  property p_gerr_hold;
    gerr_q && !fifo_empty |=> gerr_q;
  endproperty
  a_gerr_hold: assert property (p_gerr_hold) else $error("Gate error lost");

  property p_gerr_clear;
    fifo_empty && !gate_error_evt |=> !gerr_q && gt_q == GT_RESET ##1 gt_q == GT_RESET;
  endproperty
  a_gerr_clear: assert property (p_gerr_clear) else $error("Gate error not cleared");

  property p_gt_count;
    gerr_q && $past(gerr_q) && odr_tick && gt_q != GT_MAX && !fifo_empty
      |=> gt_q == $past(gt_q) + 5'h01;
  endproperty
  a_gt_count: assert property (p_gt_count) else $error("Timer not counting");

  property p_vecm_clear;
    rd_flags && !(vecm_evt && vecm_int_en) |=> !int_flags[BIT_VECM];
  endproperty
  a_vecm_clear: assert property (p_vecm_clear) else $error("Vector flag kept");

  property p_trans_keep;
    int_flags[BIT_TRANS] && !trans_src_rd |=> int_flags[BIT_TRANS];
  endproperty
  a_trans_keep: assert property (p_trans_keep) else $error("Transient flag lost");

  property p_aslp_clear;
    rd_sys && !link.aslp_evt |=> !int_flags[BIT_ASLP];
  endproperty
  a_aslp_clear: assert property (p_aslp_clear) else $error("Auto-sleep flag kept");

  property p_fifo_clear;
    fifo_status_rd && !set_v[BIT_FIFO] |=> !int_flags[BIT_FIFO];
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("FIFO flag kept");

  property p_read_data;
    reg_rd && reg_addr == ADDR_INT_FLAGS |=> reg_rdata == $past(flags_q);
  endproperty
  a_read_data: assert property (p_read_data) else $error("Bad flag readback");

  c_freeze: cover property (fifo_mode == FIFO_MODE_TRIGGER ##1 fifo_freeze);
  c_gerr: cover property (gerr_q [*3] ##1 !gerr_q);
  c_set_clr: cover property (rd_flags && vecm_evt && vecm_int_en);
endmodule : event_status_and_fifo_trigger

// file: evt_status_pkg.sv
// Constants shared by the event status and FIFO trigger logic
package evt_status_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_TRIG_SEL = 8'h0a;
  localparam logic [7:0] ADDR_SYS_MODE = 8'h0b;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h0c;
  // ==========================================================
  // Field positions of trigger select and interrupt flags, and of gate error and timer in the mode word
  localparam int BIT_DRDY = 0;
  localparam int BIT_VECM = 1;
  localparam int BIT_FFMT = 2;
  localparam int BIT_PULSE = 3;
  localparam int BIT_ORIENT = 4;
  localparam int BIT_TRANS = 5;
  localparam int BIT_FIFO = 6;
  localparam int BIT_ASLP = 7;
  localparam int BIT_GATE_ERR = 7;
  localparam int GT_LSB = 2;
  localparam int GT_W = 5;
  localparam logic [7:0] TRIG_MASK = 8'h3e;
  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [GT_W-1:0] GT_RESET = 5'h00;
  localparam logic [GT_W-1:0] GT_MAX = 5'h1f;
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] FIFO_MODE_TRIGGER = 2'h3;
  localparam int FIFO_DEPTH = 32;
endpackage : evt_status_pkg

// file: mode_link_if.sv
// Signals between the status block and its mode sequencer
`timescale 1ns/10ps
interface mode_link_if;
  logic active;
  logic slpe;
  logic inact_expired;
  logic wake_evt;
  logic aslp_evt;
  logic sleep_rate;
  logic [1:0] mode;
  modport ctl (output active, output slpe, output inact_expired, output wake_evt,
    input aslp_evt, input sleep_rate, input mode);
  modport seq (input active, input slpe, input inact_expired, input wake_evt,
    output aslp_evt, output sleep_rate, output mode);
endinterface : mode_link_if

// file: mode_sequencer.sv
// Standby, wake and sleep sequencer
`timescale 1ns/10ps
module mode_sequencer
  import evt_status_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  mode_link_if.seq link
);
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_WAKE = 3'b010,
    ST_SLEEP = 3'b100
  } mode_state_e;

  mode_state_e state_q;
  mode_state_e state_d;
  logic aslp_q;
  logic aslp_d;

  // Next state and transition event
  always_comb
  begin
    state_d = state_q;
    aslp_d = 1'b0;
    if (!link.active)
      state_d = ST_STANDBY;
    else
    begin
      unique case (state_q)
        ST_STANDBY: state_d = ST_WAKE;
        ST_WAKE:
        begin
          if (link.slpe && link.inact_expired)
          begin
            state_d = ST_SLEEP;
            aslp_d = 1'b1;
          end
        end
        ST_SLEEP:
        begin
          if (link.wake_evt)
          begin
            state_d = ST_WAKE;
            aslp_d = 1'b1;
          end
        end
        default: state_d = ST_STANDBY;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= ST_STANDBY;
      aslp_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      aslp_q <= aslp_d;
    end
  end

  // Mode code and rate select
  always_comb
  begin
    unique case (state_q)
      ST_WAKE: link.mode = MODE_WAKE;
      ST_SLEEP: link.mode = MODE_SLEEP;
      default: link.mode = MODE_STANDBY;
    endcase
  end
  assign link.sleep_rate = (state_q == ST_SLEEP);
  assign link.aslp_evt = aslp_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_to_sleep;
    link.active && state_q == ST_WAKE && link.slpe && link.inact_expired
      |=> link.mode == MODE_SLEEP && link.sleep_rate && link.aslp_evt;
  endproperty
  a_to_sleep: assert property (p_to_sleep) else $error("No wake to sleep");

  property p_to_wake;
    link.active && state_q == ST_SLEEP && link.wake_evt
      |=> link.mode == MODE_WAKE && !link.sleep_rate && link.aslp_evt;
  endproperty
  a_to_wake: assert property (p_to_wake) else $error("No sleep to wake");

  property p_aslp_cause;
    link.aslp_evt |-> $past(link.mode) != link.mode && link.mode != MODE_STANDBY;
  endproperty
  a_aslp_cause: assert property (p_aslp_cause) else $error("Stray auto-sleep event");

  property p_standby;
    !link.active |=> link.mode == MODE_STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("Not in standby");

  c_sleep_wake: cover property (link.mode == MODE_SLEEP ##[1:50] link.mode == MODE_WAKE);
endmodule : mode_sequencer

// file: host_model.sv
// Host side model issuing register reads and writes
`timescale 1ns/10ps
module host_model
(
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  logic [7:0] exp_q[$];
  initial
  begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  // ==========================================================
  // Bus cycles
  // One strobe cycle; address and data scrambled once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask : xfer
  // Read with the expected byte noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask : rd
endmodule : host_model

// file: tb_event_status_and_fifo_trigger.sv
// Self-checking bench for the event status block
`timescale 1ns/10ps
module tb_event_status_and_fifo_trigger;
  import evt_status_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, int_flags;
  logic reg_wr, reg_rd, odr_tick, active, slpe, inact, wake, fifo_wmrk, fifo_empty;
  logic gerr, fsrd, fifo_freeze, sleep_rate, due, fovf, push;
  logic [1:0] fifo_mode, sys_mode;
  logic [5:0] ev, en, srd;
  int errors = 0, num_checks = 0, cycles = 0, n, r;
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  host_model host_model_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  event_status_and_fifo_trigger event_status_and_fifo_trigger_i (.clock(clock),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .odr_tick(odr_tick), .active(active),
    .slpe(slpe), .inact_expired(inact), .wake_evt(wake), .fifo_mode(fifo_mode),
    .fifo_push(push), .fifo_ovf(fovf), .fifo_wmrk(fifo_wmrk), .fifo_empty(fifo_empty),
    .gate_error_evt(gerr), .fifo_status_rd(fsrd), .trans_event_active_flag(ev[5]),
    .trans_int_en(en[5]), .trans_src_rd(srd[5]), .orient_changed(ev[4]),
    .orient_int_en(en[4]), .orientation_state_register_rd(srd[4]),
    .pulse_event_active_flag(ev[3]), .pulse_int_en(en[3]), .pulse_src_rd(srd[3]),
    .ffmt_event_active_flag(ev[2]), .ffmt_int_en(en[2]), .ffmt_src_rd(srd[2]),
    .vecm_evt(ev[1]), .vecm_int_en(en[1]), .drdy_evt(ev[0]), .drdy_clr(srd[0]),
    .fifo_freeze(fifo_freeze), .sleep_rate(sleep_rate), .sys_mode(sys_mode),
    .int_flags(int_flags));
  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  // Read data compared with the oldest noted value
  always @(posedge clock) due <= reg_rd;
  always @(negedge clock)
    if (due)
      chk("rdata", reg_rdata, host_model_i.exp_q.pop_front());
  // Hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      results();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {odr_tick, active, slpe, inact, wake, fifo_mode, fifo_wmrk, fifo_empty} = '0;
    {gerr, fsrd, ev, en, srd, fovf, push} = '0;
    r = $urandom(14058);
    cyc(20);
    sys_rst = 1'b0;
    // Reset values, unmapped and read-only places
    host_model_i.rd(ADDR_TRIG_SEL, TRIG_RESET);
    host_model_i.rd(ADDR_SYS_MODE, 8'h00);
    host_model_i.rd(ADDR_INT_FLAGS, FLAGS_RESET);
    host_model_i.rd(8'h3f, 8'h00);
    r = $urandom;
    host_model_i.xfer(1'b1, ADDR_TRIG_SEL, r[7:0]);
    host_model_i.xfer(1'b1, ADDR_SYS_MODE, 8'hff);
    host_model_i.rd(ADDR_TRIG_SEL, r[7:0] & TRIG_MASK);
    host_model_i.rd(ADDR_SYS_MODE, 8'h00);
    // Each event: masked, set, freeze, read, clear
    for (int i = 1; i <= 5; i++)
    begin
      host_model_i.xfer(1'b1, ADDR_TRIG_SEL, TRIG_MASK ^ (8'h01 << i));
      fifo_mode = FIFO_MODE_TRIGGER;
      ev[i] = 1'b1;
      cyc(3);
      chk("flag masked", int_flags, 8'h00);
      chk("freeze masked", 8'(fifo_freeze), 8'h00);
      en[i] = 1'b1;
      cyc(3);
      chk("flag set", int_flags, 8'h01 << i);
      chk("freeze other", 8'(fifo_freeze), 8'h00);
      // Own enable only now; freeze follows a cycle after the write
      host_model_i.xfer(1'b1, ADDR_TRIG_SEL, 8'h01 << i);
      cyc(1);
      chk("freeze set", 8'(fifo_freeze), 8'h01);
      ev[i] = 1'b0;
      host_model_i.rd(ADDR_INT_FLAGS, 8'h01 << i);
      cyc(1);
      chk("after read", int_flags, (i == 1) ? 8'h00 : 8'h01 << i);
      srd[i] = 1'b1;
      cyc(1);
      {srd, en, fifo_mode} = '0;
      cyc(2);
      chk("flag cleared", int_flags, 8'h00);
      chk("freeze off", 8'(fifo_freeze), 8'h00);
    end
    // FIFO flag
    fifo_wmrk = 1'b1;
    cyc(3);
    chk("fifo flag", int_flags, 8'h40);
    fsrd = 1'b1;
    cyc(1);
    {fsrd, fifo_wmrk} = '0;
    cyc(2);
    chk("fifo clear", int_flags, 8'h00);
    // Overflow, cleared while still high, raised again by a push
    fovf = 1'b1;
    cyc(2);
    chk("ovf flag", int_flags, 8'h40);
    fsrd = 1'b1;
    cyc(1);
    fsrd = 1'b0;
    chk("ovf held clear", int_flags, 8'h00);
    push = 1'b1;
    cyc(1);
    {push, fovf} = '0;
    cyc(1);
    chk("push reflag", int_flags, 8'h40);
    fsrd = 1'b1;
    cyc(1);
    fsrd = 1'b0;
    chk("ovf clear", int_flags, 8'h00);
    // Data ready: set and clear in one cycle, set wins
    {ev[0], srd[0]} = 2'b11;
    cyc(1);
    {ev[0], srd[0]} = 2'b00;
    cyc(1);
    chk("drdy flag", int_flags, 8'h01);
    srd[0] = 1'b1;
    cyc(1);
    srd[0] = 1'b0;
    chk("drdy clear", int_flags, 8'h00);
    // Gate error and its timer
    n = $urandom_range(9, 1);
    gerr = 1'b1;
    cyc(1);
    gerr = 1'b0;
    repeat (n)
    begin
      odr_tick = 1'b1;
      cyc(1);
      odr_tick = 1'b0;
      cyc(1);
    end
    host_model_i.rd(ADDR_SYS_MODE, {1'b1, 5'(n), MODE_STANDBY});
    fifo_empty = 1'b1;
    cyc(2);
    fifo_empty = 1'b0;
    host_model_i.rd(ADDR_SYS_MODE, 8'h00);
    // Mode changes
    active = 1'b1;
    cyc(3);
    chk("wake", 8'(sys_mode), 8'(MODE_WAKE));
    host_model_i.rd(ADDR_SYS_MODE, 8'(MODE_WAKE));
    slpe = 1'b1;
    inact = 1'b1;
    cyc(1);
    inact = 1'b0;
    cyc(3);
    chk("sleep", 8'({sys_mode, sleep_rate, int_flags[7]}), 8'h0b);
    host_model_i.rd(ADDR_SYS_MODE, 8'(MODE_SLEEP));
    cyc(1);
    chk("aslp clear", int_flags, 8'h00);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(3);
    chk("rewake", 8'({sys_mode, sleep_rate, int_flags[7]}), 8'h05);
    active = 1'b0;
    cyc(3);
    chk("standby", 8'(sys_mode), 8'(MODE_STANDBY));
    cyc(2);
    results();
  end
endmodule : tb_event_status_and_fifo_trigger
